// ==== hdl/acr_core.sv ====
// Function
// (RULE1) 12-bit trim in two bytes
// (RULE2) software loads factory trim
// (RULE3) left: bits 11:4 in high
// (RULE4) left: bits 3:0 at low 7:4
// (RULE5) right: bits 11:8 at high 3:0
// (RULE6) right: sign fill if differential
// (RULE7) 8-bit: sign fill if signed
// (RULE8) right and 8-bit: low is bits 7:0
// (RULE9) 16-bit read/write threshold
// (RULE10) start bit begins, self clears
// (RULE11) start while set has no effect; a write in the CONV_STARTED cycle keeps it set for another conversion
// (RULE12) start bit aliased in control
// (RULE13) gain code picks factor
// (RULE14) unsigned: internal or single kinds
// (RULE15) signed: differential kinds too
// (RULE16) kind change flushes pipeline
// (RULE17) internal: temp, bandgap, tenth supply
// (RULE18) pin kinds: plus code n is pin n
// (RULE19) minus select only if differential
// (RULE20) plain differential minus codes
// (RULE21) amplified differential minus codes
// (RULE22) software zeroes reserved bits
// (RULE23) low-byte read latches high into hold
// (RULE24) 2-bit format code picks layout
// (RULE25) result bytes updated together
`timescale 1ns/1ps
module acr_core
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic CONV_STARTED,
    input wire logic CONV_DONE,
    input wire logic [11:0] CONV_DATA,
    output logic CONV_REQ,
    output logic PIPE_FLUSH,
    output logic [11:0] TRIM,
    output logic CONV_SIGNED,
    output acr_pkg::acr_route_t ROUTE,
    output logic [15:0] THRESHOLD,
    output logic [3:0] IRQ_CTRL
);

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [7:0] conv_cfg_reg;
    logic [7:0] chan_ctrl_reg;
    logic [7:0] input_sel_reg;
    logic [7:0] irq_ctrl_reg;
    logic [11:0] trim_reg;
    logic [15:0] threshold_reg;
    logic [7:0] hold_reg;
    logic start_reg;
    acr_pkg::acr_result_t result_reg;
    acr_pkg::acr_result_t result_next;
    acr_pkg::acr_state_t state_reg;
    logic [7:0] rdata_next;
    logic start_wr;
    logic [1:0] kind_wr;
    acr_pkg::acr_fmt_t fmt;
    acr_pkg::acr_kind_t kind;
    logic signed_mode;
    logic diff_kind;

    assign fmt = acr_pkg::acr_fmt_t'(conv_cfg_reg[acr_pkg::LSB_CFG_FMT +: 2]);
    assign kind = acr_pkg::acr_kind_t'(
        chan_ctrl_reg[acr_pkg::LSB_CH_KIND +: 2]);
    assign signed_mode = conv_cfg_reg[acr_pkg::BIT_CFG_SIGNED];
    assign diff_kind = signed_mode && kind[1]; // RULE15

    // ------------------------------------------------------------
    // start request through either alias
    // ------------------------------------------------------------
    // both aliases share one flop
    always_comb
    begin
        start_wr = 1'b0;
        if (WR && (ADDR == acr_pkg::OFS_CHAN_CTRL))
        begin
            start_wr = WDATA[acr_pkg::BIT_CH_START];
        end
        if (WR && (ADDR == acr_pkg::OFS_CONV_CTRL))
        begin
            start_wr = WDATA[acr_pkg::BIT_CTRL_GO0]; // RULE12
        end
    end

    // a write while pending is absorbed unless it meets CONV_STARTED, when it re-arms the request
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            start_reg <= 1'b0;
        end
        else if (start_wr)
        begin
            start_reg <= 1'b1; // RULE10 RULE11
        end
        else if (CONV_STARTED)
        begin
            start_reg <= 1'b0; // RULE10
        end
    end

    assign CONV_REQ = start_reg;

    // ------------------------------------------------------------
    // conversion tracking
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            state_reg <= acr_pkg::ST_IDLE;
        end
        else
        begin
            case (state_reg)
                acr_pkg::ST_IDLE:
                begin
                    if (start_reg && CONV_STARTED)
                    begin
                        state_reg <= acr_pkg::ST_BUSY;
                    end
                end
                acr_pkg::ST_BUSY:
                begin
                    if (CONV_DONE || PIPE_FLUSH)
                    begin
                        state_reg <= acr_pkg::ST_IDLE;
                    end
                end
                default:
                begin
                    state_reg <= acr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            conv_cfg_reg <= acr_pkg::RST_BYTE;
        end
        else if (WR && (ADDR == acr_pkg::OFS_CONV_CFG))
        begin
            conv_cfg_reg <= WDATA & acr_pkg::MASK_CONV_CFG; // RULE24
        end
    end

    // reserved bits are dropped, so they always read zero
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            chan_ctrl_reg <= acr_pkg::RST_BYTE;
            input_sel_reg <= acr_pkg::RST_BYTE;
            irq_ctrl_reg <= acr_pkg::RST_BYTE;
        end
        else if (WR)
        begin
            if (ADDR == acr_pkg::OFS_CHAN_CTRL)
            begin
                chan_ctrl_reg <= WDATA & acr_pkg::MASK_CHAN_CTRL; // RULE13
            end
            if (ADDR == acr_pkg::OFS_CHAN_INPUT_SEL)
            begin
                input_sel_reg <= WDATA & acr_pkg::MASK_INPUT_SEL; // RULE22
            end
            if (ADDR == acr_pkg::OFS_CHAN_IRQ_CTRL)
            begin
                irq_ctrl_reg <= WDATA & acr_pkg::MASK_IRQ_CTRL;
            end
        end
    end

    // flush when a write changes the kind
    assign kind_wr = WDATA[acr_pkg::LSB_CH_KIND +: 2];
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            PIPE_FLUSH <= 1'b0;
        end
        else
        begin
            PIPE_FLUSH <= WR && (ADDR == acr_pkg::OFS_CHAN_CTRL)
                && (kind_wr != kind); // RULE16
        end
    end

    // trim is only ever loaded by software
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            trim_reg <= acr_pkg::RST_TRIM;
        end
        else if (WR && (ADDR == acr_pkg::OFS_TRIM_LOW))
        begin
            trim_reg[7:0] <= WDATA; // RULE1 RULE2
        end
        else if (WR && (ADDR == acr_pkg::OFS_TRIM_HIGH))
        begin
            trim_reg[11:8] <= WDATA[3:0]; // RULE1
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            threshold_reg <= acr_pkg::RST_WORD;
        end
        else if (WR && (ADDR == acr_pkg::OFS_THRESHOLD_LOW))
        begin
            threshold_reg[7:0] <= WDATA; // RULE9
        end
        else if (WR && (ADDR == acr_pkg::OFS_THRESHOLD_HIGH))
        begin
            threshold_reg[15:8] <= WDATA; // RULE9
        end
    end

    // ------------------------------------------------------------
    // result formatting
    // ------------------------------------------------------------
    always_comb
    begin
        result_next.high = 8'h00;
        result_next.low = CONV_DATA[7:0]; // RULE8
        case (fmt)
            acr_pkg::FMT_LEFT12:
            begin
                result_next.high = CONV_DATA[11:4]; // RULE3
                result_next.low = {CONV_DATA[3:0], 4'h0}; // RULE4
            end
            acr_pkg::FMT_RIGHT8:
            begin
                result_next.high = {8{signed_mode & CONV_DATA[7]}}; // RULE7
            end
            default:
            begin
                // reserved code acts as right 12-bit
                result_next.high = {{4{diff_kind & CONV_DATA[11]}},
                    CONV_DATA[11:8]}; // RULE5 RULE6
            end
        endcase
    end

    // both bytes change in one edge
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            result_reg <= '0; // RULE25
        end
        else if (CONV_DONE && (state_reg == acr_pkg::ST_BUSY))
        begin
            result_reg <= result_next; // RULE25
        end
    end

    // ------------------------------------------------------------
    // input routing
    // ------------------------------------------------------------
    always_comb
    begin
        ROUTE = '0;
        ROUTE.gain_code = chan_ctrl_reg[acr_pkg::LSB_CH_GAIN +: 3]; // RULE13
        ROUTE.plus_pin = input_sel_reg[acr_pkg::LSB_SEL_PLUS +: 4];
        ROUTE.route_valid = 1'b1;
        if (kind == acr_pkg::KIND_INTERNAL)
        begin
            ROUTE.plus_pin = 4'h0;
            case (input_sel_reg[acr_pkg::LSB_SEL_PLUS +: 4]) // RULE17
                4'h0: ROUTE.plus_src = acr_pkg::SRC_TEMP;
                4'h1: ROUTE.plus_src = acr_pkg::SRC_BANDGAP;
                4'h2: ROUTE.plus_src = acr_pkg::SRC_VCC_TENTH;
                default: ROUTE.route_valid = 1'b0;
            endcase
        end
        else
        begin
            ROUTE.plus_src = acr_pkg::SRC_PIN; // RULE18
        end
        if (kind[1] && !signed_mode)
        begin
            ROUTE.route_valid = 1'b0; // RULE14
        end
        // minus side idle outside differential
        if (diff_kind) // RULE19
        begin
            ROUTE.gain_used = (kind == acr_pkg::KIND_DIFF_AMP);
            ROUTE.minus_src = acr_pkg::SRC_PIN;
            ROUTE.minus_pin = {1'b0, ROUTE.gain_used,
                input_sel_reg[1:0]}; // RULE20 RULE21
            case ({ROUTE.gain_used, input_sel_reg[2:0]})
                4'b0101: ROUTE.minus_src = acr_pkg::SRC_PAD_GND; // RULE20
                4'b0111: ROUTE.minus_src = acr_pkg::SRC_INNER_GND; // RULE20
                4'b1100: ROUTE.minus_src = acr_pkg::SRC_INNER_GND; // RULE21
                4'b1111: ROUTE.minus_src = acr_pkg::SRC_PAD_GND; // RULE21
                4'b0100, 4'b0110, 4'b1101, 4'b1110:
                begin
                    ROUTE.minus_src = acr_pkg::SRC_NONE;
                    ROUTE.route_valid = 1'b0;
                end
                default: ROUTE.minus_src = acr_pkg::SRC_PIN;
            endcase
            if (ROUTE.minus_src != acr_pkg::SRC_PIN)
            begin
                ROUTE.minus_pin = 4'h0;
            end
        end
    end

    assign TRIM = trim_reg;
    assign THRESHOLD = threshold_reg;
    assign CONV_SIGNED = signed_mode;
    assign IRQ_CTRL = irq_ctrl_reg[3:0];

    // ------------------------------------------------------------
    // shared high-byte holding register
    // ------------------------------------------------------------
    // a low read snapshots the high byte
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            hold_reg <= acr_pkg::RST_BYTE;
        end
        else if (RD && (ADDR == acr_pkg::OFS_RESULT_LOW))
        begin
            hold_reg <= result_reg.high; // RULE23
        end
        else if (RD && (ADDR == acr_pkg::OFS_THRESHOLD_LOW))
        begin
            hold_reg <= threshold_reg[15:8]; // RULE23
        end
        else if (WR && (ADDR == acr_pkg::OFS_HOLD))
        begin
            hold_reg <= WDATA;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb
    begin
        case (ADDR)
            acr_pkg::OFS_CONV_CTRL: rdata_next = {5'h00, start_reg, 2'b00};
            acr_pkg::OFS_CONV_CFG: rdata_next = conv_cfg_reg;
            acr_pkg::OFS_HOLD: rdata_next = hold_reg;
            acr_pkg::OFS_TRIM_LOW: rdata_next = trim_reg[7:0];
            acr_pkg::OFS_TRIM_HIGH: rdata_next = {4'h0, trim_reg[11:8]};
            acr_pkg::OFS_RESULT_LOW: rdata_next = result_reg.low;
            acr_pkg::OFS_RESULT_HIGH: rdata_next = hold_reg; // RULE23
            acr_pkg::OFS_THRESHOLD_LOW: rdata_next = threshold_reg[7:0];
            acr_pkg::OFS_THRESHOLD_HIGH: rdata_next = hold_reg; // RULE23
            acr_pkg::OFS_CHAN_CTRL:
                rdata_next = {start_reg, chan_ctrl_reg[6:0]}; // RULE12
            acr_pkg::OFS_CHAN_INPUT_SEL: rdata_next = input_sel_reg;
            acr_pkg::OFS_CHAN_IRQ_CTRL: rdata_next = irq_ctrl_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            RDATA <= acr_pkg::RST_BYTE;
        end
        else if (RD)
        begin
            RDATA <= rdata_next;
        end
        else
        begin
            RDATA <= acr_pkg::RST_BYTE;
        end
    end

endmodule

// ==== hdl/acr_pkg.sv ====
package acr_pkg;

    // ------------------------------------------------------------
    // register map (byte offsets on the plain register port)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CONV_CTRL = 8'h00;
    localparam logic [7:0] OFS_CONV_CFG = 8'h01;
    localparam logic [7:0] OFS_HOLD = 8'h07;
    localparam logic [7:0] OFS_TRIM_LOW = 8'h0C;
    localparam logic [7:0] OFS_TRIM_HIGH = 8'h0D;
    localparam logic [7:0] OFS_RESULT_LOW = 8'h10;
    localparam logic [7:0] OFS_RESULT_HIGH = 8'h11;
    localparam logic [7:0] OFS_THRESHOLD_LOW = 8'h18;
    localparam logic [7:0] OFS_THRESHOLD_HIGH = 8'h19;
    localparam logic [7:0] OFS_CHAN_CTRL = 8'h20;
    localparam logic [7:0] OFS_CHAN_INPUT_SEL = 8'h21;
    localparam logic [7:0] OFS_CHAN_IRQ_CTRL = 8'h22;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_CTRL_GO0 = 2;
    localparam int BIT_CFG_SIGNED = 4;
    localparam int LSB_CFG_FMT = 1;
    localparam int BIT_CH_START = 7;
    localparam int LSB_CH_GAIN = 2;
    localparam int LSB_CH_KIND = 0;
    localparam int LSB_SEL_PLUS = 3;
    localparam int LSB_SEL_MINUS = 0;

    // ------------------------------------------------------------
    // writable masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_CONV_CTRL = 8'h04;
    localparam logic [7:0] MASK_CONV_CFG = 8'h16;
    localparam logic [7:0] MASK_TRIM_HIGH = 8'h0F;
    localparam logic [7:0] MASK_CHAN_CTRL = 8'h1F;
    localparam logic [7:0] MASK_INPUT_SEL = 8'h7F;
    localparam logic [7:0] MASK_IRQ_CTRL = 8'h0F;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [11:0] RST_TRIM = 12'h000;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        FMT_RIGHT12 = 2'b00,
        FMT_RSVD = 2'b01,
        FMT_RIGHT8 = 2'b10,
        FMT_LEFT12 = 2'b11
    } acr_fmt_t;

    typedef enum logic [1:0]
    {
        KIND_INTERNAL = 2'b00,
        KIND_SINGLE = 2'b01,
        KIND_DIFF = 2'b10,
        KIND_DIFF_AMP = 2'b11
    } acr_kind_t;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01
    } acr_state_t;

    // analog route codes handed to the pipeline
    localparam logic [2:0] SRC_NONE = 3'h0;
    localparam logic [2:0] SRC_PIN = 3'h1;
    localparam logic [2:0] SRC_TEMP = 3'h2;
    localparam logic [2:0] SRC_BANDGAP = 3'h3;
    localparam logic [2:0] SRC_VCC_TENTH = 3'h4;
    localparam logic [2:0] SRC_PAD_GND = 3'h5;
    localparam logic [2:0] SRC_INNER_GND = 3'h6;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic [2:0] plus_src;
        logic [3:0] plus_pin;
        logic [2:0] minus_src;
        logic [3:0] minus_pin;
        logic [2:0] gain_code;
        logic gain_used;
        logic route_valid;
    } acr_route_t;

    typedef struct packed
    {
        logic [7:0] high;
        logic [7:0] low;
    } acr_result_t;

endpackage

// ==== verification/acr_core_props.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker for the channel control block
// ----------------------------------------------------------------
module acr_core_props
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic CONV_STARTED,
    input wire logic CONV_DONE,
    input wire logic [11:0] CONV_DATA,
    input wire logic CONV_REQ,
    input wire logic PIPE_FLUSH,
    input wire logic [11:0] TRIM,
    input wire logic CONV_SIGNED,
    input wire acr_pkg::acr_route_t ROUTE,
    input wire logic [15:0] THRESHOLD,
    input wire logic [3:0] IRQ_CTRL
);
    default clocking dc @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);
    logic [1:0] kind_reg;
    logic ch_wr;
    logic go_wr;
    // the two start bit writes
    assign ch_wr = WR && ADDR == acr_pkg::OFS_CHAN_CTRL;
    assign go_wr = (ch_wr && WDATA[7]) || (WR && WDATA[2]
        && ADDR == acr_pkg::OFS_CONV_CTRL);
    // own copy of the input kind
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
            kind_reg <= 2'h0;
        else if (ch_wr)
            kind_reg <= WDATA[1:0];
    end
    a_start_sets_req: assert property (ch_wr && WDATA[7] |=> CONV_REQ)
        else $error("no request");
    a_start_alias_go: assert property (WR && ADDR == 8'h00 && WDATA[2]
        |=> CONV_REQ)
        else $error("no alias request");
    a_req_self_clear: assert property (CONV_REQ && CONV_STARTED && !go_wr
        |=> !CONV_REQ)
        else $error("request stuck");
    a_req_holds: assert property (CONV_REQ && !CONV_STARTED && !PIPE_FLUSH
        |=> CONV_REQ)
        else $error("request lost");
    a_flush_on_change: assert property (ch_wr && WDATA[1:0] != kind_reg
        |=> PIPE_FLUSH)
        else $error("no flush");
    a_flush_only_change: assert property (PIPE_FLUSH
        |-> $past(ch_wr && WDATA[1:0] != kind_reg))
        else $error("stray flush");
    a_trim_low_write: assert property (WR && ADDR == 8'h0C
        |=> TRIM[7:0] == $past(WDATA))
        else $error("trim low");
    a_trim_high_write: assert property (WR && ADDR == 8'h0D
        |=> TRIM[11:8] == $past(WDATA[3:0]))
        else $error("trim high");
    a_thresh_low_write: assert property (WR && ADDR == 8'h18
        |=> THRESHOLD[7:0] == $past(WDATA))
        else $error("thr low");
    a_thresh_high_write: assert property (WR && ADDR == 8'h19
        |=> THRESHOLD[15:8] == $past(WDATA))
        else $error("thr high");
    a_minus_unused: assert property (!kind_reg[1]
        |-> ROUTE.minus_src == acr_pkg::SRC_NONE)
        else $error("minus used");
    a_gain_only_amp: assert property (ROUTE.gain_used
        == (CONV_SIGNED && kind_reg == 2'h3))
        else $error("gain use");
    a_signed_write: assert property (WR && ADDR == 8'h01
        |=> CONV_SIGNED == $past(WDATA[4]))
        else $error("signed bit");
    a_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
        else $error("stray read data");
endmodule

bind acr_core acr_core_props u_props
(
    .CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .CONV_STARTED(CONV_STARTED),
    .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA), .CONV_REQ(CONV_REQ),
    .PIPE_FLUSH(PIPE_FLUSH), .TRIM(TRIM), .CONV_SIGNED(CONV_SIGNED),
    .ROUTE(ROUTE), .THRESHOLD(THRESHOLD), .IRQ_CTRL(IRQ_CTRL)
);

// ==== verification/acr_pipe_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// conversion pipeline stand-in with a settable latency
// ----------------------------------------------------------------
module acr_pipe_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic conv_req,
    input wire logic [7:0] lat,
    input wire logic [11:0] data_in,
    output logic conv_started,
    output logic conv_done,
    output logic [11:0] conv_data
);
    logic [1:0] ph_reg;
    logic [7:0] cnt_reg;
    // a flush does not stop it
    always_ff @(posedge clk)
    begin
        conv_started <= 1'b0;
        conv_done <= 1'b0;
        conv_data <= ~conv_data; // valid only beside done
        if (rst)
        begin
            ph_reg <= 2'h0;
            cnt_reg <= 8'h00;
            conv_data <= 12'h000;
        end
        else if (ph_reg == 2'h0 && conv_req)
        begin
            ph_reg <= 2'h1;
            cnt_reg <= lat;
        end
        else if (ph_reg != 2'h0 && cnt_reg != 8'h00)
            cnt_reg <= cnt_reg - 8'h01;
        else if (ph_reg == 2'h1)
        begin
            conv_started <= 1'b1;
            ph_reg <= 2'h2;
            cnt_reg <= lat;
        end
        else if (ph_reg == 2'h2)
        begin
            conv_done <= 1'b1;
            conv_data <= data_in;
            ph_reg <= 2'h0;
        end
    end
endmodule

// ==== verification/test_adc_channel_result_and_input_select.sv ====
`timescale 1ns/1ps
module test_adc_channel_result_and_input_select;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] lat = 8'h00;
    logic [11:0] din = 12'h000;
    logic started, done, req, flush, sgn;
    logic [11:0] cdata, trim;
    logic [7:0] rdata;
    logic [15:0] thr;
    logic [3:0] irq;
    acr_pkg::acr_route_t route;
    logic [7:0] exp_q[$];
    logic rd_d = 1'b0;
    logic [7:0] regs[10] = '{8'h01, 8'h0C, 8'h0D, 8'h10, 8'h11, 8'h18,
        8'h19, 8'h20, 8'h21, 8'h3F};
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int n_start = 0;

    acr_core u_dut
    (
        .CLK_SYS(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .CONV_STARTED(started), .CONV_DONE(done),
        .CONV_DATA(cdata), .CONV_REQ(req), .PIPE_FLUSH(flush), .TRIM(trim),
        .CONV_SIGNED(sgn), .ROUTE(route), .THRESHOLD(thr), .IRQ_CTRL(irq)
    );
    acr_pipe_model u_pipe
    (
        .clk(clk), .rst(rst), .conv_req(req), .lat(lat), .data_in(din),
        .conv_started(started), .conv_done(done), .conv_data(cdata)
    );

    initial
    begin
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        n_checks++;
        if (seen !== want)
        begin
            num_errors++;
            $display("FAIL %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // idle cycle after each strobe
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        rd <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask
    // low byte first, high from hold
    task automatic rd16(input logic [7:0] a, input logic [15:0] e);
        rd_reg(a, e[7:0]);
        rd_reg(a + 8'h01, e[15:8]);
    endtask
    task automatic wait_done();
        for (int i = 0; i < 200 && !done; i++)
            @(posedge clk);
        check(16'(done), 16'h0001);
        @(posedge clk);
    endtask
    function automatic logic [15:0] fmt_res(input logic [1:0] f,
        input logic s, input logic [1:0] k, input logic [11:0] d);
        if (f == 2'h3)
            return {d, 4'h0};
        if (f == 2'h2)
            return {{8{s & d[7]}}, d[7:0]};
        return {{4{s & k[1] & d[11]}}, d};
    endfunction
    task automatic route_case(input logic s, input logic [1:0] k,
        input logic [3:0] p, input logic [2:0] m);
        logic ok;
        logic [2:0] ms;
        wr_reg(8'h21, {1'b0, p, m});
        ok = !(k[1] && !s) && (k != 2'h0 || p < 4'h3)
            && (k < 2'h2 || (m != (k == 2'h2 ? 3'h4 : 3'h5) && m != 3'h6));
        check(16'(route.route_valid), 16'(ok));
        if (!ok)
            return;
        ms = k < 2'h2 ? acr_pkg::SRC_NONE : m < 3'h4 ? acr_pkg::SRC_PIN
            : m == (k == 2'h2 ? 3'h5 : 3'h7) ? acr_pkg::SRC_PAD_GND
            : acr_pkg::SRC_INNER_GND;
        check(16'(route.minus_src), 16'(ms));
        if (k == 2'h0)
            check(16'(route.plus_src), 16'(p == 4'h0 ? acr_pkg::SRC_TEMP
                : p == 4'h1 ? acr_pkg::SRC_BANDGAP
                : acr_pkg::SRC_VCC_TENTH));
        else
            check(16'({route.plus_src, route.plus_pin}),
                16'({acr_pkg::SRC_PIN, p}));
        if (ms == acr_pkg::SRC_PIN)
            check(16'(route.minus_pin), 16'({k[0], m[1:0]}));
    endtask

    // read data checked in slot after strobe
    always @(posedge clk)
    begin
        rd_d <= rd;
        cycles++;
        if (started)
            n_start++;
        if (rd_d)
            check({8'h00, rdata}, {8'h00, exp_q.pop_front()});
        if (cycles > 20000)
        begin
            num_errors++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [15:0] v;
        logic [11:0] d;
        logic [1:0] k;
        logic [15:0] last;
        int n0;
        v = 16'($urandom(61230));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check(16'(route.route_valid), 16'h0001);
        wr_reg(8'h3F, 8'hA5);
        foreach (regs[j])
            rd_reg(regs[j], 8'h00);
        $display("reset test done");
        wr_reg(8'h0C, v[7:0]);
        wr_reg(8'h0D, v[15:8]);
        check(16'(trim), {4'h0, v[11:0]});
        rd_reg(8'h0D, {4'h0, v[11:8]});
        v = 16'($urandom);
        wr_reg(8'h18, v[7:0]);
        wr_reg(8'h19, v[15:8]);
        check(thr, v);
        rd16(8'h18, v);
        $display("trim and threshold test done");
        for (int f = 0; f < 4; f++)
            for (int s = 0; s < 2; s++)
            begin
                k = s ? {1'b1, 1'($urandom)} : 2'h1;
                d = 12'($urandom);
                wr_reg(8'h01, {3'h0, 1'(s), 1'b0, 2'(f), 1'b0});
                wr_reg(8'h20, {6'h00, k});
                din <= d;
                lat <= 8'($urandom % 4);
                if (f % 2)
                    wr_reg(8'h00, 8'h04);
                else
                    wr_reg(8'h20, {6'h20, k});
                wait_done();
                last = fmt_res(2'(f), 1'(s), k, d);
                rd16(8'h10, last);
            end
        $display("format test done");
        lat <= 8'h14;
        n0 = n_start;
        wr_reg(8'h20, {6'h20, k});
        rd_reg(8'h20, {6'h20, k});
        rd_reg(8'h00, 8'h04);
        wr_reg(8'h00, 8'h04);
        wait_done();
        repeat (60) @(posedge clk);
        check(16'(n_start - n0), 16'h0001);
        rd_reg(8'h20, {6'h00, k});
        rd16(8'h10, last);
        din <= ~d;
        wr_reg(8'h20, {6'h20, k});
        for (int i = 0; i < 100 && !started; i++)
            @(posedge clk);
        wr_reg(8'h20, {6'h00, ~k});
        wait_done();
        rd16(8'h10, last);
        $display("start and flush test done");
        for (int s = 0; s < 2; s++)
            for (int kk = 0; kk < 4; kk++)
            begin
                k = 2'(kk);
                wr_reg(8'h01, {3'h0, 1'(s), 4'h0});
                wr_reg(8'h20, {3'h0, 1'(s), k, k});
                check(16'(route.gain_code), 16'({1'(s), k}));
                for (int p = 0; p < 16; p++)
                    for (int m = 0; m < 8; m++)
                        route_case(1'(s), k, 4'(p), 3'(m));
            end
        wr_reg(8'h21, 8'hFF);
        rd_reg(8'h21, 8'h7F);
        wr_reg(8'h22, 8'hFF);
        check(16'(irq), 16'h000F);
        rd_reg(8'h22, 8'h0F);
        $display("input select test done");
        finish_test();
    end
endmodule
